// file: src/fp_error_signalling_unit.sv
// Floating-point error and context-switch exception logic of the processor.
// Assumes one instruction is offered per op_valid pulse and held in the issuing stage until done.
// Assumes ce is held high in every cycle in which state should advance.
//
// Function
// - Fault any floating-point instruction with device-unavailable while task-switched flag set.
// - Device-unavailable takes precedence over a pending numeric exception.
// - Nowait save with the external error line low asserts the error output.
// - Restore reloads pending flags; next waiting floating-point instruction raises numeric trap.
// - Legacy save and restore image is 94 bytes in 16-bit, 108 in 32-bit.
// - Extended save and restore image is 512 bytes.
// - Extended image address must be 16-byte aligned; misaligned is rejected.
// - Extended image uses a layout distinct from the legacy image.
// - Legacy saves reinitialise the unit; extended save leaves state unchanged.
// - Active error line is sampled before waiting instructions and vectors to 16.
// - Nowait instructions run without the error trap; the error stays pending except that a nowait save clears the flags.
// - Task-switched flag is control bit 3, set by task switches or software.
// - Nowait legacy save clears recorded errors and deasserts the error output unless the external error line is low or an unmasked raise arrives with it.
`timescale 1ns/1ps
`include "fp_error_defines.svh"
module fp_error_signalling_unit (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       ce,
    input  wire logic                       op_valid,
    input  wire fp_error_pkg::fp_op_t       op_kind,
    input  wire logic                       mode32,
    input  wire logic [31:0]                op_addr,
    input  wire logic [`EXC_BITS-1:0]       exc_raise,
    input  wire logic [`EXC_BITS-1:0]       exc_mask,
    input  wire logic [`EXC_BITS-1:0]       restore_flags,
    input  wire logic                       copro_error_n,
    input  wire logic                       hw_task_switch,
    input  wire logic                       ctrl_write,
    input  wire logic [31:0]                ctrl_wdata,
    input  wire logic                       clear_ts,
    output logic [31:0]                     main_control_register,
    output logic [`EXC_BITS-1:0]            status_flags_r,
    output logic                            fp_error_out_n,
    output logic                            trap_r,
    output logic [7:0]                      trap_vector_r,
    output logic                            op_done_r,
    output logic                            fp_reinit_r,
    output logic [9:0]                      image_bytes_r,
    output fp_error_pkg::img_fmt_t          image_fmt_r
);
    import fp_error_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Instruction classification.
    logic is_fp;
    logic waits;
    logic is_restore;
    logic is_ext;
    logic misaligned;
    logic task_switched_flag;
    logic numeric_pending;
    logic device_unavailable_fault;
    logic numeric_trap;
    logic align_fault;
    logic executes;
    logic clear_all;
    logic load_all;
    logic [`EXC_BITS-1:0] flags;
    logic [`EXC_BITS-1:0] unmasked;
    logic raise_unmasked;
    logic nowait_save_run;
    logic legacy_img;
    logic restore_unmasked;

    assign task_switched_flag = main_control_register[`TS_BIT];
    assign is_fp      = op_valid && (op_kind != OP_NONE) && (op_kind != OP_WAIT);
    assign waits      = op_valid && (op_kind inside {OP_WAIT, OP_FP_WAITING, OP_WAIT_SAVE,
                                                     OP_LEGACY_RESTORE, OP_EXT_SAVE, OP_EXT_RESTORE});
    assign is_restore = (op_kind == OP_LEGACY_RESTORE) || (op_kind == OP_EXT_RESTORE);
    assign is_ext     = (op_kind == OP_EXT_SAVE) || (op_kind == OP_EXT_RESTORE);
    // Misalignment matters only for extended ops; is_ext gates it below.
    assign misaligned = |(op_addr & `EXT_ALIGN_MASK);

    // Internal unmasked flags or the external coprocessor line make a numeric error pending.
    assign numeric_pending = (|unmasked) || !copro_error_n;

    // Device-unavailable is checked first so the numeric error is handled in its owner's context.
    // OP_WAIT is not a floating-point op, so it never takes device-unavailable.
    assign device_unavailable_fault = is_fp && task_switched_flag;
    assign numeric_trap = waits && !device_unavailable_fault && numeric_pending;
    assign align_fault  = op_valid && is_ext && misaligned &&
                          !device_unavailable_fault && !numeric_trap;
    assign executes     = op_valid && !device_unavailable_fault && !numeric_trap && !align_fault;

    assign clear_all = ce && executes &&
                       ((op_kind == OP_NOWAIT_SAVE) || (op_kind == OP_WAIT_SAVE));
    assign load_all  = ce && executes && is_restore;

    // A raise counts towards the error output only when its own mask bit is clear.
    // A masked raise beside an unmasked mask bit must not leak through.
    assign raise_unmasked   = |(exc_raise & ~exc_mask);
    assign restore_unmasked = |(restore_flags & ~exc_mask);
    // Besides a raise in the same cycle, only the external line can still be pending once a nowait save wipes the flags.
    assign nowait_save_run  = executes && (op_kind == OP_NOWAIT_SAVE) && !copro_error_n;
    assign legacy_img       = op_kind inside {OP_NOWAIT_SAVE, OP_WAIT_SAVE, OP_LEGACY_RESTORE};

    ////////////////////////////////////////////////////////////////////////
    // Exception flags.
    // Each flag sits in its own cell: a raise beats a restore load, which beats a clear.
    // The status copy trails the flags by one cycle.
    genvar i;
    generate
        for (i = 0; i < `EXC_BITS; i++) begin : g_flag
            exc_flag_reg u_flag (
                .clk      (clk),
                .nrst     (nrst),
                .en       (ce),
                .raise    (exc_raise[i]),
                .clear    (clear_all),
                .load     (load_all),
                .load_val (restore_flags[i]),
                .mask     (exc_mask[i]),
                .flag_r   (flags[i]),
                .unmasked (unmasked[i])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_flags_r <= '0;
        end else if (ce) begin
            status_flags_r <= flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register with the task-switched flag.
    // A hardware task switch is applied last so it wins over a write or clear of the flag.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            main_control_register <= `CTRL_RESET;
        end else if (ce) begin
            if (ctrl_write) begin
                main_control_register <= ctrl_wdata;
            end else if (clear_ts) begin
                main_control_register[`TS_BIT] <= 1'b0;
            end
            if (hw_task_switch) begin
                main_control_register[`TS_BIT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error output.
    // A fresh unmasked raise wins over everything so no event is hidden by a save.
    // A nowait save with the external line low pulls the output low for one cycle,
    // so that an interrupt is requested even though the save clears the flags.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fp_error_out_n <= 1'b1;
        end else if (ce) begin
            if (raise_unmasked) begin
                fp_error_out_n <= 1'b0;
            end else if (nowait_save_run) begin
                fp_error_out_n <= 1'b0;
            end else if (clear_all) begin
                fp_error_out_n <= 1'b1;
            end else if (load_all) begin
                fp_error_out_n <= ~restore_unmasked;
            end else begin
                fp_error_out_n <= ~(|unmasked);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trap and completion outputs.
    // Vector priority follows the fault priority above; a refused op leaves
    // the flags untouched because executes gates both clear and load.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trap_r        <= 1'b0;
            trap_vector_r <= 8'h00;
            op_done_r     <= 1'b0;
        end else if (ce) begin
            trap_r    <= device_unavailable_fault || numeric_trap || align_fault;
            op_done_r <= executes;
            if (device_unavailable_fault) begin
                trap_vector_r <= `VEC_DEV_UNAVAIL;
            end else if (numeric_trap) begin
                trap_vector_r <= `VEC_NUMERIC;
            end else if (align_fault) begin
                trap_vector_r <= `VEC_ALIGN;
            end else begin
                trap_vector_r <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Save image size, format and reinitialisation.
    // Size and format stand for one cycle beside op_done_r and read zero otherwise.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            image_bytes_r <= 10'h000;
            image_fmt_r   <= FMT_NONE;
            fp_reinit_r   <= 1'b0;
        end else if (ce) begin
            fp_reinit_r <= clear_all;
            if (executes && is_ext) begin
                image_bytes_r <= `EXT_IMG_BYTES;
                image_fmt_r   <= FMT_EXTENDED;
            end else if (executes && legacy_img) begin
                image_bytes_r <= mode32 ? `LEGACY_IMG_32 : `LEGACY_IMG_16;
                image_fmt_r   <= FMT_LEGACY;
            end else begin
                image_bytes_r <= 10'h000;
                image_fmt_r   <= FMT_NONE;
            end
        end
    end
endmodule // fp_error_signalling_unit

// file: src/fp_error_defines.svh
// Constants for the floating-point error signalling unit.
// Assumes inclusion by bare name from design files under src/.
`ifndef FP_ERROR_DEFINES_SVH
`define FP_ERROR_DEFINES_SVH
`define TS_BIT              3
`define CTRL_RESET          32'h0000_0000
`define VEC_DEV_UNAVAIL     8'h07
`define VEC_NUMERIC         8'h10
`define VEC_ALIGN           8'h11
`define LEGACY_IMG_16       10'h05e
`define LEGACY_IMG_32       10'h06c
`define EXT_IMG_BYTES       10'h200
`define EXT_ALIGN_MASK      32'h0000_000f
`define EXC_BITS            6
`endif

// file: src/fp_error_pkg.sv
// Types for the floating-point error signalling unit.
// Assumes fp_error_defines.svh is on the include path.
package fp_error_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_WAIT, OP_FP_WAITING, OP_FP_NOWAIT,
        OP_NOWAIT_SAVE, OP_WAIT_SAVE, OP_LEGACY_RESTORE,
        OP_EXT_SAVE, OP_EXT_RESTORE
    } fp_op_t;
    typedef enum logic [1:0] {
        FMT_NONE, FMT_LEGACY, FMT_EXTENDED
    } img_fmt_t;
endpackage

// file: src/exc_flag_reg.sv
// One sticky floating-point exception flag with mask gating.
// Assumes a single clock with active-low asynchronous reset.
`timescale 1ns/1ps
module exc_flag_reg (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic en,
    input  wire logic raise,
    input  wire logic clear,
    input  wire logic load,
    input  wire logic load_val,
    input  wire logic mask,
    output logic      flag_r,
    output logic      unmasked
);
    // A raise in the clearing cycle wins so no event is lost.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_r <= 1'b0;
        end else if (en) begin
            if (raise) begin
                flag_r <= 1'b1;
            end else if (load) begin
                flag_r <= load_val;
            end else if (clear) begin
                flag_r <= 1'b0;
            end
        end
    end

    assign unmasked = flag_r & ~mask;
endmodule // exc_flag_reg

// file: testbench/fp_error_signalling_unit_sva.sv
// Checker of the floating-point error unit, watching its ports only.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ps
module fp_error_signalling_unit_sva
    import fp_error_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   nrst,
    input wire logic                   ce,
    input wire logic                   op_valid,
    input wire fp_error_pkg::fp_op_t   op_kind,
    input wire logic                   mode32,
    input wire logic [31:0]            op_addr,
    input wire logic [5:0]             exc_raise,
    input wire logic                   copro_error_n,
    input wire logic                   hw_task_switch,
    input wire logic [31:0]            main_control_register,
    input wire logic                   fp_error_out_n,
    input wire logic                   trap_r,
    input wire logic [7:0]             trap_vector_r,
    input wire logic                   op_done_r,
    input wire logic                   fp_reinit_r,
    input wire logic [9:0]             image_bytes_r,
    input wire fp_error_pkg::img_fmt_t image_fmt_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic go;
    logic calm;
    logic ext;
    assign go = ce && op_valid && !main_control_register[3];
    assign calm = copro_error_n && fp_error_out_n;
    assign ext = op_kind == OP_EXT_SAVE || op_kind == OP_EXT_RESTORE;
    dev_fault_a: assert property (ce && op_valid && main_control_register[3] && op_kind != OP_WAIT
        && op_kind != OP_NONE |=> trap_r && trap_vector_r == 8'h07) else $error("no device fault");
    numeric_trap_a: assert property (go && !calm && op_kind inside {OP_WAIT, OP_FP_WAITING}
        |=> trap_r && trap_vector_r == 8'h10) else $error("no numeric trap");
    nowait_run_a: assert property (go && op_kind == OP_FP_NOWAIT |=> op_done_r && !trap_r)
        else $error("nowait op trapped");
    save_size_a: assert property (go && op_kind == OP_NOWAIT_SAVE |=> fp_reinit_r && image_fmt_r == FMT_LEGACY
        && image_bytes_r == ($past(mode32) ? 10'h06c : 10'h05e)) else $error("legacy save wrong");
    save_clear_a: assert property (go && op_kind == OP_NOWAIT_SAVE && copro_error_n && exc_raise == 6'h00
        |=> fp_error_out_n [*2]) else $error("error output not cleared");
    align_fault_a: assert property (go && calm && ext && op_addr[3:0] != 4'h0
        |=> trap_r && trap_vector_r == 8'h11) else $error("misalignment not refused");
    ext_image_a: assert property (go && calm && ext && op_addr[3:0] == 4'h0 |=> op_done_r && !fp_reinit_r
        && image_bytes_r == 10'h200 && image_fmt_r == FMT_EXTENDED) else $error("extended image wrong");
    ts_set_a: assert property (ce && hw_task_switch |=> main_control_register[3])
        else $error("task switch flag not set");
    nowait_error_a: assert property (go && op_kind == OP_NOWAIT_SAVE && !copro_error_n |=> !fp_error_out_n)
        else $error("nowait save hid the error");
endmodule // fp_error_signalling_unit_sva

// file: testbench/copro_model.sv
// Coprocessor side: holds its error line low while an exception is recorded.
// Assumes the unit's clock and active-low asynchronous reset.
`timescale 1ns/1ps
module copro_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic raise,
    input  wire logic clear,
    output logic      copro_error_n
);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) copro_error_n <= 1'b1;
        else if (raise) copro_error_n <= 1'b0;
        else if (clear) copro_error_n <= 1'b1;
    end
endmodule // copro_model

// file: testbench/fp_error_signalling_unit_tb.sv
// Self-checking bench of the floating-point error unit.
// Assumes the unit, its package and the coprocessor model are compiled first.
`timescale 1ns/1ps
module fp_error_signalling_unit_tb;
    import fp_error_pkg::*;
    typedef struct {fp_op_t k; logic m; logic [31:0] a; logic [7:0] v; logic [9:0] b;} row_t;
    logic        clk, nrst, op_valid, mode32, copro_error_n, hw_task_switch, ctrl_write, clear_ts, m_raise, m_clear;
    logic        fp_error_out_n, trap_r, op_done_r, fp_reinit_r, ce;
    fp_op_t      op_kind;
    img_fmt_t    image_fmt_r;
    logic [31:0] op_addr, ctrl_wdata, main_control_register;
    logic [5:0]  exc_raise, exc_mask, restore_flags, status_flags_r;
    logic [7:0]  trap_vector_r;
    logic [9:0]  image_bytes_r;
    int          n_mismatch = 0, cmp_count = 0, cycles = 0;
    row_t        rows [8] = '{'{OP_FP_NOWAIT, 0, 0, 0, 0}, '{OP_NOWAIT_SAVE, 0, 0, 0, 10'h05e},
        '{OP_WAIT_SAVE, 1, 0, 0, 10'h06c}, '{OP_LEGACY_RESTORE, 1, 0, 0, 10'h06c}, '{OP_EXT_SAVE, 0, 32'h10, 0, 10'h200},
        '{OP_EXT_RESTORE, 1, 32'h20, 0, 10'h200}, '{OP_EXT_SAVE, 0, 32'h18, 8'h11, 0}, '{OP_EXT_RESTORE, 0, 1, 8'h11, 0}};
    fp_error_signalling_unit i_dut (.clk(clk), .nrst(nrst), .ce(ce), .op_valid(op_valid), .op_kind(op_kind),
        .mode32(mode32), .op_addr(op_addr), .exc_raise(exc_raise), .exc_mask(exc_mask), .restore_flags(restore_flags),
        .copro_error_n(copro_error_n), .hw_task_switch(hw_task_switch), .ctrl_write(ctrl_write),
        .ctrl_wdata(ctrl_wdata), .clear_ts(clear_ts), .main_control_register(main_control_register),
        .status_flags_r(status_flags_r), .fp_error_out_n(fp_error_out_n), .trap_r(trap_r),
        .trap_vector_r(trap_vector_r), .op_done_r(op_done_r), .fp_reinit_r(fp_reinit_r),
        .image_bytes_r(image_bytes_r), .image_fmt_r(image_fmt_r));
    copro_model i_copro (.clk(clk), .nrst(nrst), .raise(m_raise), .clear(m_clear), .copro_error_n(copro_error_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 400) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Lets one idle cycle pass, offers one op at a falling edge and checks the answer one cycle later.
    task automatic do_op(input fp_op_t k, input logic m, input logic [31:0] a, input logic [7:0] v);
        @(negedge clk);
        op_kind = k;
        mode32 = m;
        op_addr = a;
        op_valid = 1'b1;
        @(negedge clk);
        op_valid = 1'b0;
        chk("trap and vector", {22'h0, v != 0, v == 0, v}, {22'h0, trap_r, op_done_r, trap_vector_r});
    endtask
    initial begin
        {nrst, op_valid, mode32, hw_task_switch, ctrl_write, clear_ts, m_raise, m_clear} = '0;
        {op_addr, ctrl_wdata, exc_raise, exc_mask, restore_flags} = '0;
        op_kind = OP_NONE;
        ce = 1'b1;
        repeat (2) @(negedge clk);
        chk("error output in reset", 1, fp_error_out_n);
        nrst = 1'b1;
        foreach (rows[i]) begin
            do_op(rows[i].k, rows[i].m, rows[i].a, rows[i].v);
            chk("image bytes", rows[i].b, image_bytes_r);
        end
        $display("table test done");
        ctrl_wdata = 32'h8;
        ctrl_write = 1'b1;
        @(negedge clk);
        ctrl_write = 1'b0;
        do_op(OP_FP_WAITING, 0, 0, 8'h07);
        exc_raise = 6'h01;
        @(negedge clk);
        exc_raise = 6'h00;
        do_op(OP_FP_WAITING, 0, 0, 8'h07);
        do_op(OP_WAIT, 0, 0, 8'h10);
        clear_ts = 1'b1;
        @(negedge clk);
        clear_ts = 1'b0;
        do_op(OP_FP_NOWAIT, 0, 0, 0);
        chk("error still pending", 0, fp_error_out_n);
        do_op(OP_NOWAIT_SAVE, 1, 0, 0);
        chk("error output cleared", 1, fp_error_out_n);
        hw_task_switch = 1'b1;
        @(negedge clk);
        hw_task_switch = 1'b0;
        chk("task switched flag", 1, main_control_register[3]);
        clear_ts = 1'b1;
        @(negedge clk);
        clear_ts = 1'b0;
        $display("task switch test done");
        restore_flags = 6'h02;
        do_op(OP_LEGACY_RESTORE, 1, 0, 0);
        restore_flags = 6'h00;
        chk("error after restore", 0, fp_error_out_n);
        do_op(OP_FP_WAITING, 0, 0, 8'h10);
        do_op(OP_NOWAIT_SAVE, 0, 0, 0);
        exc_mask = 6'h3f;
        exc_raise = 6'h04;
        @(negedge clk);
        exc_raise = 6'h00;
        chk("masked error output", 1, fp_error_out_n);
        do_op(OP_FP_WAITING, 0, 0, 0);
        chk("masked flag kept", 6'h04, status_flags_r);
        do_op(OP_NOWAIT_SAVE, 0, 0, 0);
        exc_mask = 6'h00;
        m_raise = 1'b1;
        @(negedge clk);
        m_raise = 1'b0;
        do_op(OP_FP_WAITING, 0, 0, 8'h10);
        do_op(OP_NOWAIT_SAVE, 0, 0, 0);
        chk("error on nowait save", 0, fp_error_out_n);
        m_clear = 1'b1;
        @(negedge clk);
        m_clear = 1'b0;
        $display("error line test done");
        ce = 1'b0;
        exc_raise = 6'h01;
        @(negedge clk);
        exc_raise = 6'h00;
        ce = 1'b1;
        chk("frozen error output", 1, fp_error_out_n);
        @(negedge clk);
        chk("frozen flags", 0, status_flags_r);
        $display("clock enable test done");
        finish_test();
    end
endmodule // fp_error_signalling_unit_tb
bind fp_error_signalling_unit fp_error_signalling_unit_sva i_sva (.clk(clk), .nrst(nrst), .ce(ce),
    .op_valid(op_valid), .op_kind(op_kind), .mode32(mode32), .op_addr(op_addr), .exc_raise(exc_raise),
    .copro_error_n(copro_error_n), .hw_task_switch(hw_task_switch), .main_control_register(main_control_register),
    .fp_error_out_n(fp_error_out_n), .trap_r(trap_r), .trap_vector_r(trap_vector_r), .op_done_r(op_done_r),
    .fp_reinit_r(fp_reinit_r), .image_bytes_r(image_bytes_r), .image_fmt_r(image_fmt_r));
